// *** logic/timer_two_pkg.sv ***
// package: register map, bit positions and timing constants of the timer-two block
package timer_two_pkg;
    // register byte addresses (word aligned)
    localparam logic [3:0] addr_control = 4'h0;
    localparam logic [3:0] addr_count = 4'h4;
    localparam logic [3:0] addr_capture = 4'h8;
    localparam int addr_width = 4;
    // control register bit positions
    localparam int bit_count_source_select = 0;
    localparam int bit_capture_reload_select = 1;
    localparam int bit_run_control = 2;
    localparam int bit_ext_trigger_enable = 3;
    localparam int bit_rx_baud_clock_select = 4;
    localparam int bit_tx_baud_clock_select = 5;
    localparam int bit_ext_trigger_flag = 6;
    localparam int bit_overflow_flag = 7;
    // reset values
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam logic [15:0] capture_reset = 16'h0000;
    // machine cycle in oscillator periods, and phase positions within it
    localparam int osc_per_machine_cycle = 12;
    localparam logic [3:0] sample_phase = 4'h9;
    localparam logic [3:0] update_phase = 4'h4;
    localparam logic [3:0] phase_last = 4'(osc_per_machine_cycle - 1);
    typedef enum logic [1:0] {
        mode_off = 2'b00,
        mode_reload = 2'b01,
        mode_capture = 2'b10,
        mode_baud = 2'b11
    } mode_t;
endpackage

// *** logic/falling_edge_sampler.sv ***
// falling-edge detector sampling a pin once per machine cycle
`timescale 1ns/100ps
module falling_edge_sampler (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sample_en,
    input wire logic pin,
    output logic fall
);
    logic prev_reg;
    logic cur_reg;

    // two samples a machine cycle apart: high then low marks an edge
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prev_reg <= 1'b1;
            cur_reg <= 1'b1;
        end else if (sample_en) begin
            prev_reg <= cur_reg;
            cur_reg <= pin;
        end
    end

    assign fall = prev_reg & ~cur_reg;
endmodule

// *** logic/timer_two_capture_counter.sv ***
// timer-two counter with external capture, as an avalon-mm slave
`timescale 1ns/100ps
module timer_two_capture_counter
    import timer_two_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [addr_width-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic count_input_pin,
    input wire logic trigger_input_pin,
    output logic overflow_flag,
    output logic ext_trigger_flag
);
    // ------------------------------------------------------------
    // machine cycle phase divider
    // ------------------------------------------------------------
    logic [3:0] phase_reg;
    wire sample_en = (phase_reg == sample_phase);
    wire update_en = (phase_reg == update_phase);
    wire cycle_en = (phase_reg == phase_last);

    always_ff @(posedge mclk) begin
        if (sys_rst || cycle_en) begin
            phase_reg <= 4'h0;
        end else begin
            phase_reg <= phase_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // pin edge detection
    // ------------------------------------------------------------
    logic count_fall;
    logic trig_fall;

    // per-cycle samples mean pulses shorter than a cycle may be missed
    falling_edge_sampler count_edge (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .sample_en(sample_en),
        .pin(count_input_pin),
        .fall(count_fall)
    );

    falling_edge_sampler trig_edge (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .sample_en(sample_en),
        .pin(trigger_input_pin),
        .fall(trig_fall)
    );

    // an edge is seen at sample_phase and held until the next update_phase
    logic count_pend_reg;
    logic trig_pend_reg;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_pend_reg <= 1'b0;
            trig_pend_reg <= 1'b0;
        end else if (cycle_en) begin
            count_pend_reg <= count_fall;
            trig_pend_reg <= trig_fall;
        end else if (update_en) begin
            count_pend_reg <= 1'b0;
            trig_pend_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control and mode decode
    // ------------------------------------------------------------
    logic [7:0] control_reg;
    logic [7:0] count_high_reg;
    logic [7:0] count_low_reg;
    logic [7:0] capture_high_reg;
    logic [7:0] capture_low_reg;

    wire run_control = control_reg[bit_run_control];
    wire count_source_select = control_reg[bit_count_source_select];
    wire capture_reload_select = control_reg[bit_capture_reload_select];
    wire ext_trigger_enable = control_reg[bit_ext_trigger_enable];
    wire baud_any = control_reg[bit_tx_baud_clock_select] | control_reg[bit_rx_baud_clock_select];

    mode_t mode;
    assign mode = !run_control ? mode_off :
                  baud_any ? mode_baud :
                  capture_reload_select ? mode_capture : mode_reload;

    wire capture_mode = (mode == mode_capture);
    wire tick = count_source_select ? (update_en & count_pend_reg) : cycle_en;
    wire count_step = capture_mode & tick;
    wire [15:0] count_now = {count_high_reg, count_low_reg};
    wire [16:0] count_sum = {1'b0, count_now} + 17'h00001;
    wire overflow = count_step & count_sum[16];
    wire trigger_hit = capture_mode & ext_trigger_enable & update_en & trig_pend_reg;

    // ------------------------------------------------------------
    // avalon-mm slave, one wait state on reads
    // ------------------------------------------------------------
    logic rd_done_reg;
    wire sel_control = (avs_address == addr_control);
    wire sel_count = (avs_address == addr_count);
    wire sel_capture = (avs_address == addr_capture);
    wire wr_control = avs_write & sel_control & avs_byteenable[0];
    wire wr_count_lo = avs_write & sel_count & avs_byteenable[0];
    wire wr_count_hi = avs_write & sel_count & avs_byteenable[1];
    wire wr_cap_lo = avs_write & sel_capture & avs_byteenable[0];
    wire wr_cap_hi = avs_write & sel_capture & avs_byteenable[1];

    assign avs_waitrequest = avs_read & ~rd_done_reg;

    wire [31:0] read_mux = sel_control ? {24'h000000, control_reg} :
                           sel_count ? {16'h0000, count_now} :
                           sel_capture ? {16'h0000, capture_high_reg, capture_low_reg} :
                           32'h00000000;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rd_done_reg <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            rd_done_reg <= avs_read & ~rd_done_reg;
            if (avs_read & ~rd_done_reg) begin
                avs_readdata <= read_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // control register and sticky flags
    // ------------------------------------------------------------
    logic [7:0] control_next;
    always_comb begin
        control_next = control_reg;
        if (wr_control) begin
            control_next = avs_writedata[7:0];
        end
        // hardware set wins over a same-cycle software clear
        if (overflow) begin
            control_next[bit_overflow_flag] = 1'b1;
        end
        if (trigger_hit) begin
            control_next[bit_ext_trigger_flag] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            control_reg <= control_reset;
        end else begin
            control_reg <= control_next;
        end
    end

    assign overflow_flag = control_reg[bit_overflow_flag];
    assign ext_trigger_flag = control_reg[bit_ext_trigger_flag];

    // ------------------------------------------------------------
    // count and capture registers
    // ------------------------------------------------------------
    // counting takes priority over a software write landing on the same step
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {count_high_reg, count_low_reg} <= count_reset;
        end else if (count_step) begin
            {count_high_reg, count_low_reg} <= count_sum[15:0];
        end else begin
            if (wr_count_lo) begin
                count_low_reg <= avs_writedata[7:0];
            end
            if (wr_count_hi) begin
                count_high_reg <= avs_writedata[15:8];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {capture_high_reg, capture_low_reg} <= capture_reset;
        end else if (trigger_hit) begin
            capture_high_reg <= count_high_reg;
            capture_low_reg <= count_low_reg;
        end else begin
            if (wr_cap_lo) begin
                capture_low_reg <= avs_writedata[7:0];
            end
            if (wr_cap_hi) begin
                capture_high_reg <= avs_writedata[15:8];
            end
        end
    end
endmodule

// *** tb/timer_two_assertions.sv ***
// concurrent checks on the timer-two bus handshake and flag outputs
`timescale 1ns/100ps
module timer_two_checker
    import timer_two_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [addr_width-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic count_input_pin,
    input wire logic trigger_input_pin,
    input wire logic overflow_flag,
    input wire logic ext_trigger_flag
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    wire unmapped = avs_address != addr_control && avs_address != addr_count
        && avs_address != addr_capture;
    sequence s_rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    property p_wr_nowait;
        avs_write |-> !avs_waitrequest;
    endproperty
    property p_rd_first_wait;
        $rose(avs_read) |-> avs_waitrequest;
    endproperty
    property p_rd_one_wait;
        avs_read && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_unmapped_zero;
        s_rd_done ##0 unmapped |-> avs_readdata == 32'h0;
    endproperty
    property p_ctrl_flags;
        s_rd_done ##0 (avs_address == addr_control) |->
            avs_readdata[7:6] == {$past(overflow_flag), $past(ext_trigger_flag)};
    endproperty
    property p_ovf_hold;
        overflow_flag && !avs_write |=> overflow_flag;
    endproperty
    property p_ext_hold;
        ext_trigger_flag && !avs_write |=> ext_trigger_flag;
    endproperty
    property p_ovf_clear_cause;
        $fell(overflow_flag) |-> $past(avs_write) && $past(avs_address) == addr_control;
    endproperty
    property p_rst_clear;
        disable iff (1'b0) sys_rst |=> !overflow_flag && !ext_trigger_flag;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    a_rd_first_wait: assert property (p_rd_first_wait) else $error("read not stalled");
    a_rd_one_wait: assert property (p_rd_one_wait) else $error("read wait too long");
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not 0");
    a_ctrl_flags: assert property (p_ctrl_flags) else $error("flag readback wrong");
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");
    a_ext_hold: assert property (p_ext_hold) else $error("trigger flag dropped");
    a_ovf_clear_cause: assert property (p_ovf_clear_cause) else $error("flag self-cleared");
    a_rst_clear: assert property (p_rst_clear) else $error("flags set in reset");
endmodule
bind timer_two_capture_counter timer_two_checker chk (.mclk, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .count_input_pin, .trigger_input_pin, .overflow_flag,
    .ext_trigger_flag);

// *** tb/pin_source.sv ***
// model of the external count and trigger signal sources
`timescale 1ns/100ps
module pin_source (
    input wire logic mclk,
    output logic count_input_pin,
    output logic trigger_input_pin
);
    initial begin
        count_input_pin = 1'b1;
        trigger_input_pin = 1'b1;
    end
    // each level held exactly one machine cycle: the fastest the sampler can follow
    task automatic pulse(input bit trig, input int n);
        repeat (n) begin
            @(posedge mclk);
            {trigger_input_pin, count_input_pin} <= trig ? 2'b01 : 2'b10;
            repeat (12) @(posedge mclk);
            {trigger_input_pin, count_input_pin} <= 2'b11;
            repeat (11) @(posedge mclk);
        end
        repeat (24) @(posedge mclk);
    endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the timer-two capture counter
`timescale 1ns/100ps
module tb_top
    import timer_two_pkg::*;
;
    logic mclk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
    logic [3:0] avs_address = 0, avs_byteenable = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, e;
    logic avs_waitrequest, count_input_pin, trigger_input_pin, overflow_flag, ext_trigger_flag;
    logic [31:0] seed = 32'h3690b4c5;
    logic [31:0] expq[$];
    logic [7:0] off_modes[4] = '{8'h0b, 8'h0d, 8'h1f, 8'h2f};
    logic [15:0] r;
    int fails = 0, n_compared = 0;
    timer_two_capture_counter dut (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .count_input_pin, .trigger_input_pin, .overflow_flag, .ext_trigger_flag);
    pin_source far (.mclk, .count_input_pin, .trigger_input_pin);
    initial forever #2.5 mclk = ~mclk;
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one idle edge after each release keeps back-to-back requests apart
    task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_read <= rd;
        avs_write <= !rd;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= 4'hf;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
        if (n >= 20) begin
            fails++;
            $display("[FAIL] %0t bus request timed out", $time);
            stop_test();
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        expq.push_back(x);
        bus(1'b1, a, 32'h0);
    endtask
    // the flag pins are level outputs, so they are settled between bus requests
    task automatic check_flags(input logic ovf, input logic ext);
        n_compared++;
        if (overflow_flag !== ovf || ext_trigger_flag !== ext) begin
            fails++;
            $display("[FAIL] %0t flag pins %b%b expected %b%b", $time,
                overflow_flag, ext_trigger_flag, ovf, ext);
        end
    endtask
    always @(posedge mclk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            e = expq.pop_front();
            n_compared++;
            if (avs_readdata !== e) begin
                fails++;
                $display("[FAIL] %0t read %h expected %h", $time, avs_readdata, e);
            end
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        r = 16'(xs() & 32'h7fff);
        rd(addr_control, 32'h0);
        check_flags(1'b0, 1'b0);
        bus(1'b0, addr_control, 32'h0f);
        bus(1'b0, addr_count, {16'h0, r});
        rd(addr_count, {16'h0, r});
        far.pulse(1'b0, 5);
        rd(addr_count, 32'(r + 16'd5));
        far.pulse(1'b1, 1);
        rd(addr_capture, 32'(r + 16'd5));
        rd(addr_control, 32'h4f);
        check_flags(1'b0, 1'b1);
        bus(1'b0, addr_control, 32'h0f);
        rd(addr_control, 32'h0f);
        check_flags(1'b0, 1'b0);
        bus(1'b0, addr_count, 32'hffff);
        far.pulse(1'b0, 1);
        rd(addr_count, 32'h0);
        rd(addr_control, 32'h8f);
        check_flags(1'b1, 1'b0);
        foreach (off_modes[i]) begin
            bus(1'b0, addr_control, {24'h0, off_modes[i]});
            far.pulse(1'b0, 2);
            rd(addr_count, 32'h0);
        end
        bus(1'b0, addr_control, 32'h07);
        far.pulse(1'b1, 1);
        rd(addr_capture, 32'(r + 16'd5));
        rd(addr_control, 32'h07);
        check_flags(1'b0, 1'b0);
        bus(1'b0, addr_count, 32'hfffe);
        bus(1'b0, addr_control, 32'h0e);
        repeat (118) @(posedge mclk);
        bus(1'b0, addr_control, 32'h0a);
        rd(addr_count, 32'h8);
        rd(4'hc, 32'h0);
        stop_test();
    end
endmodule
